// ==== hw/rpm_top.sv ====
// Receive pattern match: registers, frame tracking and match decision
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module rpm_top (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_eof_i,
  output logic match_o
);
  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] pat_word [rpm_pkg::PAT_WORDS];
  logic [15:0] next_pat_word [rpm_pkg::PAT_WORDS];
  logic [15:0] mask_word [rpm_pkg::MASK_WORDS];
  logic [15:0] next_mask_word [rpm_pkg::MASK_WORDS];
  logic [rpm_pkg::START_W-1:0] start;
  logic [rpm_pkg::START_W-1:0] next_start;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  rpm_pkg::rpm_state_e state;
  rpm_pkg::rpm_state_e next_state;
  logic match;
  logic next_match;
  logic last_match;
  logic next_last_match;

  logic [rpm_pkg::PAT_BYTES*rpm_pkg::BYTE_W-1:0] pat_bytes;
  logic [rpm_pkg::PAT_BYTES-1:0] mask_bits;
  logic [rpm_pkg::PAT_BYTES-1:0] lane_ok;
  logic frame_ok;

  logic [15:0] pat_off;
  logic [15:0] mask_off;
  logic pat_sel;
  logic mask_sel;
  logic [rpm_pkg::PAT_IDX_W-1:0] pat_idx;
  logic [rpm_pkg::MASK_IDX_W-1:0] mask_idx;

  // ****************************************
  // Address decode
  // ****************************************
  assign pat_off = reg_addr_i - rpm_pkg::ADDR_PAT_FIRST;
  assign mask_off = reg_addr_i - rpm_pkg::ADDR_MASK_LOW;
  assign pat_sel = (reg_addr_i >= rpm_pkg::ADDR_PAT_FIRST) &&
                   (pat_off < 16'(rpm_pkg::PAT_WORDS));
  assign mask_sel = (reg_addr_i >= rpm_pkg::ADDR_MASK_LOW) &&
                    (mask_off < 16'(rpm_pkg::MASK_WORDS));
  assign pat_idx = pat_off[rpm_pkg::PAT_IDX_W-1:0];
  assign mask_idx = mask_off[rpm_pkg::MASK_IDX_W-1:0];

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    next_pat_word = pat_word;
    next_mask_word = mask_word;
    next_start = start;
    if (reg_wr_i) begin
      if (pat_sel) begin
        next_pat_word[pat_idx] = reg_wdata_i;
      end
      if (mask_sel) begin
        next_mask_word[mask_idx] = reg_wdata_i;
      end
      if (reg_addr_i == rpm_pkg::ADDR_CTRL) begin
        next_start = reg_wdata_i[rpm_pkg::START_W-1:0];
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    next_rdata = '0;
    if (reg_rd_i) begin
      if (pat_sel) begin
        next_rdata = pat_word[pat_idx];
      end else if (mask_sel) begin
        next_rdata = mask_word[mask_idx];
      end else if (reg_addr_i == rpm_pkg::ADDR_CTRL) begin
        next_rdata = 16'(start);
      end else if (reg_addr_i == rpm_pkg::ADDR_STATUS) begin
        next_rdata[rpm_pkg::STAT_MATCH_BIT] = last_match;
        next_rdata[rpm_pkg::STAT_BUSY_BIT] = (state == rpm_pkg::ST_RECV);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int w = 0; w < rpm_pkg::PAT_WORDS; w++) begin
        pat_word[w] <= rpm_pkg::PAT_RESET;
      end
      for (int k = 0; k < rpm_pkg::MASK_WORDS; k++) begin
        mask_word[k] <= rpm_pkg::MASK_RESET;
      end
      start <= rpm_pkg::START_RESET;
      rdata <= '0;
    end else begin
      pat_word <= next_pat_word;
      mask_word <= next_mask_word;
      start <= next_start;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // ****************************************
  // Pattern and mask layout
  // ****************************************
  always_comb begin
    pat_bytes = '0;
    mask_bits = '0;
    for (int w = 0; w < rpm_pkg::PAT_WORDS; w++) begin
      pat_bytes[w*rpm_pkg::WORD_W +: rpm_pkg::WORD_W] = pat_word[w];
    end
    for (int k = 0; k < rpm_pkg::MASK_WORDS; k++) begin
      mask_bits[k*rpm_pkg::WORD_W +: rpm_pkg::WORD_W] = mask_word[k];
    end
  end

  // ****************************************
  // Byte stream and comparators
  // ****************************************
  rpm_cmp_if cmp_bus();

  assign cmp_bus.sof = rx_sof_i;
  assign cmp_bus.byte_vld = rx_valid_i && !rx_sof_i && (state == rpm_pkg::ST_RECV);
  assign cmp_bus.byte_val = rx_byte_i;

  rpm_pos_cnt u_pos (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start),
    .cmp(cmp_bus)
  );

  for (genvar g = 0; g < rpm_pkg::PAT_BYTES; g++) begin : g_lane
    rpm_lane #(
      .LANE(g)
    ) u_lane (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .pat_byte_i(pat_bytes[g*rpm_pkg::BYTE_W +: rpm_pkg::BYTE_W]),
      .mask_i(mask_bits[g]),
      .cmp(cmp_bus),
      .ok_o(lane_ok[g])
    );
  end

  // Masked bytes pass even when the frame is too short to reach them
  assign frame_ok = &(lane_ok | mask_bits);

  // ****************************************
  // Frame tracking and match decision
  // ****************************************
  always_comb begin
    next_state = state;
    next_match = 1'b0;
    next_last_match = last_match;
    unique case (state)
      rpm_pkg::ST_IDLE: begin
        if (rx_sof_i) begin
          next_state = rpm_pkg::ST_RECV;
        end
      end
      rpm_pkg::ST_RECV: begin
        if (rx_sof_i) begin
          next_state = rpm_pkg::ST_RECV;
        end else if (rx_eof_i) begin
          next_state = rpm_pkg::ST_IDLE;
          next_match = frame_ok;
          next_last_match = frame_ok;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= rpm_pkg::ST_IDLE;
      match <= 1'b0;
      last_match <= 1'b0;
    end else begin
      state <= next_state;
      match <= next_match;
      last_match <= next_last_match;
    end
  end

  assign match_o = match;
endmodule

// ==== hw/rpm_pkg.sv ====
// Constants and types of the receive pattern match block
// What this block does
// - Mask word two covers bytes 16 to 31
// - Mask word three covers bytes 32 to 47
// - Mask word four covers bytes 48 to 63
// - Control bits 5:0 set compare start offset
// - Offset N skips N bytes, compares from byte N
// - Start offset resets to twelve
// - Pattern is 32 words, even byte low
// - Mask word one covers bytes 0 to 15
package rpm_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned PAT_BYTES = 64;
  localparam int unsigned PAT_WORDS = 32;
  localparam int unsigned PAT_IDX_W = 5;
  localparam int unsigned MASK_WORDS = 4;
  localparam int unsigned MASK_IDX_W = 2;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned POS_W = 8;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_PAT_FIRST = 16'h04a8;
  localparam logic [15:0] ADDR_MASK_LOW = 16'h04c8;
  localparam logic [15:0] ADDR_MASK_MID_LOW = 16'h04c9;
  localparam logic [15:0] ADDR_MASK_MID_HIGH = 16'h04ca;
  localparam logic [15:0] ADDR_MASK_TOP = 16'h04cb;
  localparam logic [15:0] ADDR_CTRL = 16'h04cc;
  localparam logic [15:0] ADDR_STATUS = 16'h04cd;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned START_W = 6;
  localparam logic [5:0] START_RESET = 6'h0c;
  localparam logic [15:0] PAT_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam int unsigned STAT_MATCH_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  // ****************************************
  // Frame state
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RECV = 2'b10
  } rpm_state_e;
endpackage

// ==== hw/rpm_cmp_if.sv ====
// Byte stream and compare position shared by counter and lanes
`timescale 1ns/1ps
interface rpm_cmp_if;
  logic sof;
  logic byte_vld;
  logic [rpm_pkg::BYTE_W-1:0] byte_val;
  logic [rpm_pkg::IDX_W-1:0] idx;
  logic hit;
  modport src(output sof, output byte_vld, output byte_val);
  modport cnt(input sof, input byte_vld, output idx, output hit);
  modport lane(input sof, input byte_vld, input byte_val, input idx, input hit);
endinterface

// ==== hw/rpm_pos_cnt.sv ====
// Byte position counter after the frame delimiter
`timescale 1ns/1ps
module rpm_pos_cnt (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [rpm_pkg::START_W-1:0] start_i,
  rpm_cmp_if.cnt cmp
);
  logic [rpm_pkg::POS_W-1:0] pos;
  logic [rpm_pkg::POS_W-1:0] next_pos;
  logic [rpm_pkg::POS_W-1:0] start_ext;
  logic [rpm_pkg::POS_W-1:0] offs;

  // Saturates so long frames never wrap into the window again
  always_comb begin
    next_pos = pos;
    if (cmp.sof) begin
      next_pos = '0;
    end else if (cmp.byte_vld && (pos != '1)) begin
      next_pos = pos + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos <= '0;
    end else begin
      pos <= next_pos;
    end
  end

  assign start_ext = rpm_pkg::POS_W'(start_i);
  assign offs = pos - start_ext;
  assign cmp.idx = offs[rpm_pkg::IDX_W-1:0];
  assign cmp.hit = (pos >= start_ext) && (offs < rpm_pkg::POS_W'(rpm_pkg::PAT_BYTES));
endmodule

// ==== hw/rpm_lane.sv ====
// One pattern byte comparator
`timescale 1ns/1ps
module rpm_lane #(
  parameter int unsigned LANE = 0
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [rpm_pkg::BYTE_W-1:0] pat_byte_i,
  input wire logic mask_i,
  rpm_cmp_if.lane cmp,
  output logic ok_o
);
  localparam logic [rpm_pkg::IDX_W-1:0] LANE_IDX = rpm_pkg::IDX_W'(LANE);
  logic ok;
  logic next_ok;

  always_comb begin
    next_ok = ok;
    if (cmp.sof) begin
      next_ok = 1'b0;
    end else if (cmp.byte_vld && cmp.hit && (cmp.idx == LANE_IDX)) begin
      next_ok = mask_i | (cmp.byte_val == pat_byte_i);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ok <= 1'b0;
    end else begin
      ok <= next_ok;
    end
  end

  assign ok_o = ok;
endmodule

// ==== verif/rpm_top_properties.sv ====
// Checker on the ports of the receive pattern match top
`timescale 1ns/1ps
module rpm_props (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_eof_i,
  input wire logic match_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [15:0] a = reg_addr_i;
  wire logic ctl = a == rpm_pkg::ADDR_CTRL;
  wire logic msk = a >= rpm_pkg::ADDR_MASK_LOW && a <= rpm_pkg::ADDR_MASK_TOP;
  wire logic pat = a >= rpm_pkg::ADDR_PAT_FIRST && a < rpm_pkg::ADDR_MASK_LOW;
  wire logic bad = a > rpm_pkg::ADDR_STATUS || a < rpm_pkg::ADDR_PAT_FIRST;
  logic [6:0] shadow;
  logic [6:0] next_shadow;
  // ****************************************
  // Shadow of start offset and frame flag
  // ****************************************
  always_comb begin
    next_shadow = shadow;
    if (reg_wr_i && ctl) next_shadow[5:0] = reg_wdata_i[5:0];
    if (rx_sof_i) next_shadow[6] = 1'b1;
    else if (rx_eof_i) next_shadow[6] = 1'b0;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) shadow <= {1'b0, rpm_pkg::START_RESET};
    else shadow <= next_shadow;
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero without read");
  a_ctrl_read_value: assert property (reg_rd_i && ctl |=> reg_rdata_o == {10'h000, $past(shadow[5:0])})
    else $error("start offset read wrong");
  a_mask_read_back: assert property (reg_rd_i && msk && $past(reg_wr_i) && $past(a) == a |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("mask word read back wrong");
  a_pat_read_back: assert property (reg_rd_i && pat && $past(reg_wr_i) && $past(a) == a |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("pattern word read back wrong");
  a_unmapped_zero: assert property (reg_rd_i && bad |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_match_after_eof: assert property (!rx_eof_i |=> !match_o)
    else $error("match without frame end");
  a_match_one_cycle: assert property (match_o |=> !match_o)
    else $error("match longer than one cycle");
  a_status_busy_bit: assert property (reg_rd_i && a == rpm_pkg::ADDR_STATUS |=> reg_rdata_o[1] == $past(shadow[6]))
    else $error("frame flag wrong");
  c_match: cover property (match_o);
  c_ctrl_rd: cover property (reg_wr_i && ctl ##1 reg_rd_i && ctl);
  c_busy_rd: cover property (reg_rd_i && a == rpm_pkg::ADDR_STATUS && shadow[6]);
endmodule
bind rpm_top rpm_props chk_u (.*);

// ==== verif/rpm_station.sv ====
// Remote station model sending received frames
`timescale 1ns/1ps
module rpm_station (
  input wire logic core_clk_i,
  output logic rx_sof_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_eof_o
);
  initial begin
    rx_sof_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_eof_o = 1'b0;
  end
  // Idle gap cycles between bytes show the inverted byte
  task automatic send(input logic [7:0] q[$], input int gap);
    @(posedge core_clk_i);
    rx_sof_o <= 1'b1;
    @(posedge core_clk_i);
    rx_sof_o <= 1'b0;
    foreach (q[i]) begin
      rx_valid_o <= 1'b1;
      rx_byte_o <= q[i];
      @(posedge core_clk_i);
      if (gap > 0) begin
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~q[i];
        repeat (gap) @(posedge core_clk_i);
      end
    end
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~q[$];
    rx_eof_o <= 1'b1;
    @(posedge core_clk_i);
    rx_eof_o <= 1'b0;
  endtask
endmodule

// ==== verif/tb_rpm_top.sv ====
// Self-checking bench of the receive pattern match block
`timescale 1ns/1ps
module tb_rpm_top;
  typedef struct {
    logic [5:0] st;
    int k;
    logic [15:0] m;
    int flip;
    logic e;
  } rpm_row_s;
  logic core_clk_i;
  logic rst_b_i;
  logic [15:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic rx_sof_i;
  logic rx_valid_i;
  logic [7:0] rx_byte_i;
  logic rx_eof_i;
  logic match_o;
  logic [15:0] mv;
  int fail_count = 0;
  int compares = 0;
  rpm_row_s rows[9] = '{'{6'h00, 0, 16'h0000, 99, 1'b1}, '{6'h0c, 1, 16'h0000, 20, 1'b0},
    '{6'h0c, 1, 16'h0010, 20, 1'b1}, '{6'h03, 2, 16'h8000, 47, 1'b1},
    '{6'h03, 2, 16'h4000, 47, 1'b0}, '{6'h3f, 3, 16'h0001, 48, 1'b1},
    '{6'h01, 3, 16'h8000, 63, 1'b1}, '{6'h01, 0, 16'h0001, 0, 1'b1},
    '{6'h01, 0, 16'h0002, 0, 1'b0}};
  rpm_top dut_u (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rx_sof_i, .rx_valid_i, .rx_byte_i, .rx_eof_i, .match_o);
  rpm_station st_u (.core_clk_i, .rx_sof_o(rx_sof_i), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .rx_eof_o(rx_eof_i));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [7:0] pb(input int b);
    return 8'(b) ^ 8'h3c;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write then read back at once, or read only
  task automatic acc(input logic [15:0] a, input logic [15:0] d, input bit w,
                     input logic [15:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    if (w) begin
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b1;
    end
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, e);
  endtask
  // Frame of pre filler bytes then 64 pattern bytes, at most one corrupted
  task automatic run(input int pre, input int flip, input int gap, input logic [7:0] x,
                     input logic e);
    logic [7:0] q[$];
    repeat (pre) q.push_back(8'hee);
    for (int b = 0; b < 64; b++) q.push_back((b == flip ? 8'hff : 8'h00) ^ (x & pb(b)));
    st_u.send(q, gap);
    #1;
    check({15'h0000, match_o}, {15'h0000, e});
  endtask
  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk_i);
    fail_count++;
    conclude();
  end
  initial begin
    rst_b_i = 1'b0;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    acc(rpm_pkg::ADDR_CTRL, 16'h0000, 0, 16'h000c);
    for (int a = 16'h04a8; a <= 16'h04cb; a++) acc(16'(a), 16'h0000, 0, 16'h0000);
    run(12, 99, 0, 8'h00, 1'b1);
    run(11, 99, 0, 8'h00, 1'b0);
    fork
      run(12, 99, 1, 8'h00, 1'b1);
      begin
        repeat (4) @(posedge core_clk_i);
        acc(rpm_pkg::ADDR_STATUS, 16'hffff, 1, 16'h0002);
      end
    join
    acc(rpm_pkg::ADDR_STATUS, 16'h0000, 0, 16'h0001);
    for (int w = 0; w < 32; w++) begin
      mv = {pb(2 * w + 1), pb(2 * w)};
      acc(rpm_pkg::ADDR_PAT_FIRST + 16'(w), mv, 1, mv);
    end
    foreach (rows[i]) begin
      for (int k = 0; k < 4; k++) begin
        mv = (k == rows[i].k) ? rows[i].m : 16'h0000;
        acc(rpm_pkg::ADDR_MASK_LOW + 16'(k), mv, 1, mv);
      end
      acc(rpm_pkg::ADDR_CTRL, {10'h3ff, rows[i].st}, 1, {10'h000, rows[i].st});
      run(rows[i].st, rows[i].flip, 0, 8'hff, rows[i].e);
    end
    acc(16'h0500, 16'h1234, 1, 16'h0000);
    acc(16'h04a7, 16'h0000, 0, 16'h0000);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    acc(rpm_pkg::ADDR_CTRL, 16'h0000, 0, 16'h000c);
    acc(rpm_pkg::ADDR_MASK_TOP, 16'h0000, 0, 16'h0000);
    acc(rpm_pkg::ADDR_MASK_LOW, 16'h0000, 0, 16'h0000);
    acc(rpm_pkg::ADDR_PAT_FIRST, 16'h0000, 0, 16'h0000);
    conclude();
  end
endmodule
